// ==== core/rsp_pkg.sv ====
// What this block does
// - stack pointer is five bits, values zero through thirty-one
// - push increments then writes; pop reads top then decrements
// - every device reset forces the pointer to zero
// - software reads and overwrites the pointer through its register
// - thirty-one pushes with no pop set the full flag
// - full flag sticks until software clear or power-on reset only
// - reset-enable set: 31st push stores pc+2, sets full, resets device
// - reset-enable clear: pointer saturates at 31, entry 31 never overwritten
// - pop on empty stack returns zero, sets underflow, pointer stays zero
// - underflow flag sticks until software clear or power-on reset
// - underflow return of zero touches no other register but the underflow flag and its interrupt status bit
// - explicit push stores current pc as new top entry
// - explicit pop only decrements, exposing the previous entry
// - top entry readable and writable as upper, high, low bytes
// - pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer 4-0
package rsp_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int unsigned RSP_PC_W     = 21;
    localparam int unsigned RSP_PTR_W    = 5;
    localparam int unsigned RSP_DEPTH    = 31;
    localparam int unsigned RSP_ADDR_W   = 14;
    localparam logic [4:0]  RSP_PTR_RST  = 5'h00;
    localparam logic [4:0]  RSP_PTR_NEAR = 5'h1e;  // next push is the 31st
    localparam logic [4:0]  RSP_PTR_MAX  = 5'h1f;
    localparam logic [20:0] RSP_PC_INC   = 21'h0_0002;
    localparam logic        RSP_ORE_RST  = 1'b1;

    // ****************************************
    // register indices; byte address is four times the index
    // ****************************************
    localparam logic [11:0] RSP_IDX_TOP_UP = 12'h0fff;
    localparam logic [11:0] RSP_IDX_TOP_HI = 12'h0ffe;
    localparam logic [11:0] RSP_IDX_TOP_LO = 12'h0ffd;
    localparam logic [11:0] RSP_IDX_PTR  = 12'h0ffc;
    localparam logic [11:0] RSP_IDX_CFG  = 12'h0000;
    localparam logic [11:0] RSP_IDX_IST  = 12'h0001;
    localparam logic [11:0] RSP_IDX_IMSK = 12'h0002;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int unsigned RSP_BIT_FULL  = 7;
    localparam int unsigned RSP_BIT_UNF   = 6;
    localparam int unsigned RSP_BIT_ORE   = 0;
    localparam int unsigned RSP_IRQ_FULL  = 0;
    localparam int unsigned RSP_IRQ_UNF   = 1;
    localparam logic [1:0]  RSP_IRQ_RST   = 2'h0;
    localparam logic [31:0] RSP_RDATA_RST = 32'h0000_0000;

    // request from the instruction sequencer
    typedef struct packed {
        logic                push;
        logic                pop;
        logic [RSP_PC_W-1:0] pc;
    } rsp_seq_req_s;

endpackage : rsp_pkg

// ==== core/rsp_stack_ctrl.sv ====
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rsp_stack_ctrl (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output var  logic                 pready_ff,
    output var  logic [31:0]          prdata_ff,
    output var  logic                 pslverr_ff,
    input  wire rsp_pkg::rsp_seq_req_s seq_req,
    input  wire logic                 dev_reset_req,
    output var  logic [rsp_pkg::RSP_PC_W-1:0] ret_pc_ff,
    output var  logic                 ret_valid_ff,
    output var  logic                 stack_reset_req_ff,
    output var  logic                 irq_ff
);
    import rsp_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [RSP_PTR_W-1:0] ptr_ff;
    logic                 full_ff;
    logic                 unf_ff;
    logic                 ore_ff;
    logic [1:0]           ist_ff;
    logic [1:0]           imsk_ff;
    logic [RSP_PC_W-1:0]  mem_ff [1:RSP_DEPTH];
    logic [RSP_PC_W-1:0]  top_entry;
    logic [23:0]          top_pad;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic [13:0] byte_addr(input logic [11:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

    function automatic logic hit(input logic [31:0] a, input logic [11:0] idx);
        hit = (a == {18'h0_0000, byte_addr(idx)});
    endfunction : hit

    function automatic logic [7:0] lane(input logic [23:0] v, input logic [1:0] sel);
        lane = v[8*sel +: 8];
    endfunction : lane

    // apb phases: one wait state, then pready for a single cycle
    logic acc_start;
    logic acc_done;
    logic wr_done;
    logic mapped;
    assign acc_start = psel & penable & ~pready_ff;
    assign acc_done  = psel & penable & pready_ff;
    assign wr_done   = acc_done & pwrite;
    assign mapped    = hit(paddr, RSP_IDX_TOP_UP) | hit(paddr, RSP_IDX_TOP_HI)
                     | hit(paddr, RSP_IDX_TOP_LO) | hit(paddr, RSP_IDX_PTR)
                     | hit(paddr, RSP_IDX_CFG)  | hit(paddr, RSP_IDX_IST)
                     | hit(paddr, RSP_IDX_IMSK);

    logic wr_ptr;
    logic wr_top;
    assign wr_ptr = wr_done & hit(paddr, RSP_IDX_PTR);
    assign wr_top = wr_done & (hit(paddr, RSP_IDX_TOP_UP) | hit(paddr, RSP_IDX_TOP_HI)
                             | hit(paddr, RSP_IDX_TOP_LO));

    // sequencer requests; device reset blocks them, push beats pop
    logic hw_push;
    logic hw_pop;
    logic at_top;
    logic empty;
    assign hw_push = seq_req.push & ~dev_reset_req;
    assign hw_pop  = seq_req.pop & ~seq_req.push & ~dev_reset_req;
    assign at_top  = (ptr_ff >= RSP_PTR_NEAR);
    assign empty   = (ptr_ff == RSP_PTR_RST);

    // empty stack shows zero as its top entry
    assign top_entry = empty ? '0 : mem_ff[ptr_ff];
    assign top_pad   = 24'(top_entry);

    // ****************************************
    // pointer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff <= RSP_PTR_RST;
        end else if (dev_reset_req) begin
            ptr_ff <= RSP_PTR_RST;
        end else if (hw_push) begin
            if (!at_top) begin
                ptr_ff <= ptr_ff + 5'h01;
            end else begin
                ptr_ff <= ore_ff ? RSP_PTR_RST : RSP_PTR_MAX;
            end
        end else if (hw_pop) begin
            ptr_ff <= empty ? RSP_PTR_RST : ptr_ff - 5'h01;
        end else if (wr_ptr) begin
            ptr_ff <= pwdata[RSP_PTR_W-1:0];
        end
    end

    // ****************************************
    // stack storage, no reset: contents are don't-care until pushed
    // ****************************************
    logic [23:0] top_merge;
    always_comb begin
        top_merge = top_pad;
        if (hit(paddr, RSP_IDX_TOP_UP)) begin
            top_merge[23:16] = pwdata[7:0];
        end else if (hit(paddr, RSP_IDX_TOP_HI)) begin
            top_merge[15:8] = pwdata[7:0];
        end else begin
            top_merge[7:0] = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (hw_push && ptr_ff != RSP_PTR_MAX) begin
            if (ptr_ff == RSP_PTR_NEAR && ore_ff) begin
                mem_ff[ptr_ff + 5'h01] <= seq_req.pc + RSP_PC_INC;
            end else begin
                mem_ff[ptr_ff + 5'h01] <= seq_req.pc;
            end
        end else if (wr_top && !hw_push && !hw_pop && !empty) begin
            mem_ff[ptr_ff] <= top_merge[RSP_PC_W-1:0];
        end
    end

    // ****************************************
    // sticky flags, power-on reset only; a set beats a clear
    // ****************************************
    logic set_full;
    logic set_unf;
    logic nxt_full;
    logic nxt_unf;
    assign set_full = hw_push & at_top;
    assign set_unf  = hw_pop & empty;
    assign nxt_full = set_full | (full_ff & ~(wr_ptr & ~pwdata[RSP_BIT_FULL]));
    assign nxt_unf  = set_unf | (unf_ff & ~(wr_ptr & ~pwdata[RSP_BIT_UNF]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_ff <= 1'b0;
            unf_ff  <= 1'b0;
        end else begin
            full_ff <= nxt_full;
            unf_ff  <= nxt_unf;
        end
    end

    // ****************************************
    // return value to the sequencer
    // ****************************************
    // underflow just hands back zero; no register besides the flag and its interrupt status bit moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_pc_ff    <= '0;
            ret_valid_ff <= 1'b0;
        end else begin
            ret_valid_ff <= hw_pop;
            if (hw_pop) begin
                ret_pc_ff <= top_entry;
            end
        end
    end

    // overflow reset pulse to the reset controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_reset_req_ff <= 1'b0;
        end else begin
            stack_reset_req_ff <= set_full & ore_ff;
        end
    end

    // ****************************************
    // configuration, interrupt status and mask
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ore_ff <= RSP_ORE_RST;
        end else if (wr_done && hit(paddr, RSP_IDX_CFG)) begin
            ore_ff <= pwdata[RSP_BIT_ORE];
        end
    end

    logic [1:0] ist_set;
    logic [1:0] ist_clr;
    assign ist_set = {set_unf, set_full};
    assign ist_clr = (wr_done && hit(paddr, RSP_IDX_IST)) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_ff  <= RSP_IRQ_RST;
            imsk_ff <= RSP_IRQ_RST;
        end else begin
            ist_ff <= ist_set | (ist_ff & ~ist_clr);
            if (wr_done && hit(paddr, RSP_IDX_IMSK)) begin
                imsk_ff <= pwdata[1:0];
            end
        end
    end

    // one cycle behind the status bit, keeps the output a plain flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(ist_ff & imsk_ff);
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(paddr, RSP_IDX_PTR)) begin
            rd_mux[RSP_BIT_FULL]     = full_ff;
            rd_mux[RSP_BIT_UNF]      = unf_ff;
            rd_mux[RSP_PTR_W-1:0]    = ptr_ff;
        end else if (hit(paddr, RSP_IDX_TOP_UP)) begin
            rd_mux[7:0] = lane(top_pad, 2'd2);
        end else if (hit(paddr, RSP_IDX_TOP_HI)) begin
            rd_mux[7:0] = lane(top_pad, 2'd1);
        end else if (hit(paddr, RSP_IDX_TOP_LO)) begin
            rd_mux[7:0] = lane(top_pad, 2'd0);
        end else if (hit(paddr, RSP_IDX_CFG)) begin
            rd_mux[RSP_BIT_ORE] = ore_ff;
        end else if (hit(paddr, RSP_IDX_IST)) begin
            rd_mux[1:0] = ist_ff;
        end else if (hit(paddr, RSP_IDX_IMSK)) begin
            rd_mux[1:0] = imsk_ff;
        end
    end

    // read data is sampled in the wait cycle and held through pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= RSP_RDATA_RST;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= acc_start;
            if (acc_start) begin
                prdata_ff  <= pwrite ? RSP_RDATA_RST : rd_mux;
                pslverr_ff <= ~mapped;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence push_below_top_s;
        hw_push && !at_top;
    endsequence
    sequence push_31st_s;
        hw_push && ptr_ff == RSP_PTR_NEAR;
    endsequence
    sequence pop_empty_s;
        hw_pop && empty;
    endsequence

    push_inc_a: assert property (push_below_top_s |=>
        ptr_ff == 5'($past(ptr_ff) + 5'h01) && top_entry == $past(seq_req.pc))
        else $error("push did not advance pointer and store pc");
    pop_dec_a: assert property (hw_pop && !empty |=>
        ptr_ff == 5'($past(ptr_ff) - 5'h01) && ret_pc_ff == $past(top_entry)
        && ret_valid_ff)
        else $error("pop did not return top and decrement");
    dev_reset_a: assert property (dev_reset_req |=> ptr_ff == RSP_PTR_RST)
        else $error("device reset left pointer nonzero");
    sw_ptr_wr_a: assert property (wr_ptr && !hw_push && !hw_pop && !dev_reset_req
        |=> ptr_ff == $past(pwdata[4:0]))
        else $error("software pointer write lost");
    full_set_a: assert property (push_31st_s |=> full_ff && ist_ff[RSP_IRQ_FULL])
        else $error("31st push did not set full");
    full_hold_a: assert property (full_ff && !(wr_ptr && !pwdata[RSP_BIT_FULL])
        |=> full_ff)
        else $error("full flag dropped without software clear");
    ovf_reset_a: assert property (push_31st_s and ore_ff |=>
        ptr_ff == RSP_PTR_RST && stack_reset_req_ff
        && mem_ff[RSP_DEPTH] == $past(seq_req.pc) + RSP_PC_INC ##1 !stack_reset_req_ff)
        else $error("overflow reset sequence wrong");
    sat_hold_a: assert property (hw_push && ptr_ff == RSP_PTR_MAX && !ore_ff
        |=> ptr_ff == RSP_PTR_MAX && $stable(mem_ff[RSP_DEPTH]) && full_ff)
        else $error("saturated push moved pointer or entry");
    underflow_a: assert property (pop_empty_s |=>
        ret_pc_ff == '0 && unf_ff && ptr_ff == RSP_PTR_RST && $stable(ore_ff))
        else $error("empty pop misbehaved");
    unf_hold_a: assert property (unf_ff && !(wr_ptr && !pwdata[RSP_BIT_UNF])
        |=> unf_ff)
        else $error("underflow flag dropped without software clear");
    apb_wait_a: assert property (acc_start |=> pready_ff ##1 !pready_ff)
        else $error("apb answer not one wait state");

endmodule : rsp_stack_ctrl
`default_nettype wire

// ==== tb/rsp_seq_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// instruction sequencer stand-in: one push or pop per call
module rsp_seq_model (
    input  wire logic                         pclk,
    output var  rsp_pkg::rsp_seq_req_s        seq_req,
    input  wire logic [rsp_pkg::RSP_PC_W-1:0] ret_pc,
    input  wire logic                         ret_valid
);
    import rsp_pkg::*;

    // idle at time zero
    initial begin
        seq_req = '{push: 1'b0, pop: 1'b0, pc: '0};
    end

    // pc shows the inverse once released, so a stale value is never reused
    task automatic do_push(input logic [RSP_PC_W-1:0] pc);
        @(posedge pclk);
        seq_req.push <= 1'b1;
        seq_req.pc   <= pc;
        @(posedge pclk);
        seq_req.push <= 1'b0;
        seq_req.pc   <= ~pc;
    endtask : do_push

    // return value lands the cycle after the pop is taken
    task automatic do_pop(output logic [RSP_PC_W-1:0] got, output logic vld);
        @(posedge pclk);
        seq_req.pop <= 1'b1;
        @(posedge pclk);
        seq_req.pop <= 1'b0;
        @(posedge pclk);
        got = ret_pc;
        vld = ret_valid;
    endtask : do_pop
endmodule : rsp_seq_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rsp_pkg::*;

    logic                 pclk, presetn, psel, penable, pwrite, dev_reset_req;
    logic [31:0]          paddr, pwdata, prdata_ff;
    logic                 pready_ff, pslverr_ff, ret_valid_ff, stack_reset_req_ff, irq_ff;
    logic [RSP_PC_W-1:0]  ret_pc_ff;
    rsp_seq_req_s         seq_req;
    int                   n_mismatch, cmp_count;

    localparam logic [31:0] A_PTR  = {18'h0, RSP_IDX_PTR, 2'b00};
    localparam logic [31:0] A_TOP_U = {18'h0, RSP_IDX_TOP_UP, 2'b00};
    localparam logic [31:0] A_TOP_H = {18'h0, RSP_IDX_TOP_HI, 2'b00};
    localparam logic [31:0] A_TOP_L = {18'h0, RSP_IDX_TOP_LO, 2'b00};
    localparam logic [31:0] A_CFG  = {18'h0, RSP_IDX_CFG, 2'b00};
    localparam logic [31:0] A_IST  = {18'h0, RSP_IDX_IST, 2'b00};
    localparam logic [31:0] A_MSK  = {18'h0, RSP_IDX_IMSK, 2'b00};

    rsp_stack_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready_ff(pready_ff),
        .prdata_ff(prdata_ff), .pslverr_ff(pslverr_ff), .seq_req(seq_req),
        .dev_reset_req(dev_reset_req), .ret_pc_ff(ret_pc_ff), .ret_valid_ff(ret_valid_ff),
        .stack_reset_req_ff(stack_reset_req_ff), .irq_ff(irq_ff));

    rsp_seq_model seq (.pclk(pclk), .seq_req(seq_req), .ret_pc(ret_pc_ff),
        .ret_valid(ret_valid_ff));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // bus master
    // ****************************************
    // request held until pready is seen at an edge; bounded wait
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd_d, output logic err);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready_ff !== 1'b1 && i < 20);
        if (pready_ff !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: bus timeout", $time);
            test_done();
        end else begin
            rd_d = prdata_ff;
            err  = pslverr_ff;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        chk({31'h0, e}, 32'h0);
        chk(d, exp);
    endtask : rd

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr

    // pop through the sequencer and check the returned pc
    task automatic pop_chk(input logic [31:0] exp);
        logic [RSP_PC_W-1:0] g;
        logic                v;
        seq.do_pop(g, v);
        chk({31'h0, v}, 32'h1);
        chk({11'h0, g}, exp);
    endtask : pop_chk

    task automatic dev_rst();
        @(posedge pclk);
        dev_reset_req <= 1'b1;
        @(posedge pclk);
        dev_reset_req <= 1'b0;
    endtask : dev_rst

    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        logic [31:0] q;
        logic        e;
        n_mismatch = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        dev_reset_req = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_PTR, 32'h0);
        rd(A_CFG, 32'h1);
        apb(1'b0, 32'h0000_0100, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        wr(A_MSK, 32'h3);
        // two calls, then the top entry bytes
        seq.do_push(21'h0_1234);
        seq.do_push(21'h15_a3c7);
        rd(A_PTR, 32'h2);
        rd(A_TOP_U, 32'h15);
        rd(A_TOP_H, 32'ha3);
        wr(A_TOP_L, 32'h5a);
        rd(A_TOP_L, 32'h5a);
        pop_chk(32'h0015_a35a);
        rd(A_PTR, 32'h1);
        pop_chk(32'h0000_1234);
        // underflow: zero returned, flag and interrupt raised
        pop_chk(32'h0);
        rd(A_PTR, 32'h40);
        chk({31'h0, irq_ff}, 32'h1);
        rd(A_CFG, 32'h1);
        rd(A_MSK, 32'h3);
        dev_rst();
        rd(A_PTR, 32'h40);
        wr(A_IST, 32'h2);
        rd(A_IST, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq_ff}, 32'h0);
        wr(A_PTR, 32'h05);
        rd(A_PTR, 32'h05);
        // saturating overflow with reset disabled
        wr(A_CFG, 32'h0);
        wr(A_PTR, 32'h0);
        for (int i = 1; i <= 30; i++) begin
            seq.do_push(21'(i));
        end
        rd(A_PTR, 32'h1e);
        seq.do_push(21'h1f);
        rd(A_PTR, 32'h9f);
        seq.do_push(21'h77);
        rd(A_PTR, 32'h9f);
        rd(A_TOP_L, 32'h1f);
        pop_chk(32'h1f);
        rd(A_PTR, 32'h9e);
        // overflow with reset enabled stores pc plus two
        wr(A_CFG, 32'h1);
        wr(A_PTR, 32'h1e);
        seq.do_push(21'h0_4000);
        @(posedge pclk);
        chk({31'h0, stack_reset_req_ff}, 32'h1);
        rd(A_PTR, 32'h80);
        wr(A_PTR, 32'h9f);
        rd(A_TOP_H, 32'h40);
        rd(A_TOP_L, 32'h02);
        dev_rst();
        rd(A_PTR, 32'h80);
        rd(A_IST, 32'h1);
        // power-on reset in mid-run clears flags too
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_PTR, 32'h0);
        rd(A_CFG, 32'h1);
        test_done();
    end
endmodule : tb
`default_nettype wire
